// ### design/bfs_chan.sv
`timescale 1ns/1ps
`default_nettype none
module bfs_chan import bfs_pkg::*; #(
	parameter bit SKIP_OK = 1'b0
) (
	input  wire logic             clk_in,
	input  wire logic             arst_n_in,
	input  wire bfs_tmr_t         ss_cyc_in,
	input  wire logic             run_ok_in,
	input  wire logic             go_in,
	input  wire logic             forced_pulse_width_mode_in,
	input  wire logic             ilim_hit_in,
	input  wire logic             zero_cur_in,
	input  wire logic             ref_above_fb_in,
	input  wire logic             min_on_short_in,
	output logic                  hs_on_out,
	output logic                  ls_on_out,
	output logic                  rev_block_out,
	output logic                  skip_out,
	output logic                  soft_out,
	output logic                  run_out,
	output logic                  hiccup_out,
	output logic      [OCP_W-1:0] ocp_cnt_out
);

	bfs_chst_e        st_q, st_d;
	bfs_tmr_t         tmr_q, tmr_d;
	logic [HIC_W-1:0] per_q, per_d;
	logic [OCP_W-1:0] ocp_d;
	logic             to_hic_q, to_hic_d, prebias_d;

	wire             act      = st_q == CH_SOFT || st_q == CH_RUN;
	wire             tmr_end  = tmr_q == ss_cyc_in - bfs_tmr_t'(1);
	wire [OCP_W-1:0] ocp_inc  = ocp_cnt_out + OCP_W'(ilim_hit_in);
	wire             ocp_trip = act && ocp_inc == OCP_LIMIT;
	wire             skip_d   = SKIP_OK && forced_pulse_width_mode_in && min_on_short_in;
	wire             act_d    = st_d == CH_SOFT || st_d == CH_RUN;
	wire             hs_d     = act_d && !ilim_hit_in && !skip_d;
	// low side held off while the precharge guard stands, drain included,
	// so a cut start never pulls reverse current from a precharged output
	wire             ls_d     = (act_d || st_d == CH_DRAIN) && !prebias_d;

	always_comb begin
		st_d      = st_q;
		tmr_d     = tmr_q;
		per_d     = per_q;
		to_hic_d  = to_hic_q;
		ocp_d     = ocp_cnt_out;
		prebias_d = rev_block_out;
		unique case (st_q)
			CH_OFF: if (run_ok_in && go_in) begin
				st_d      = CH_SOFT;
				tmr_d     = '0;
				ocp_d     = '0;
				prebias_d = 1'b1;
			end
			CH_SOFT, CH_RUN: begin
				ocp_d = ocp_inc;
				if (st_q == CH_SOFT)
					tmr_d = tmr_q + bfs_tmr_t'(1);
				if (ref_above_fb_in)
					prebias_d = 1'b0;
				if (!run_ok_in) begin
					st_d     = CH_DRAIN;
					to_hic_d = 1'b0;
				end else if (ocp_trip) begin
					st_d     = CH_DRAIN;
					to_hic_d = 1'b1;
				end else if (st_q == CH_SOFT && tmr_end)
					st_d = CH_RUN;
			end
			// low side stays on, save while the precharge guard holds it off, until inductor current reaches zero
			CH_DRAIN: if (zero_cur_in) begin
				st_d  = to_hic_q ? CH_HICCUP : CH_OFF;
				tmr_d = '0;
				per_d = '0;
			end
			CH_HICCUP: if (!run_ok_in)
				st_d = CH_OFF;
			else if (tmr_end) begin
				tmr_d = '0;
				per_d = per_q + HIC_W'(1);
				if (per_q == HICCUP_PERIODS - HIC_W'(1)) begin
					st_d      = CH_SOFT;
					ocp_d     = '0;
					prebias_d = 1'b1;
				end
			end else
				tmr_d = tmr_q + bfs_tmr_t'(1);
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_q          <= CH_OFF;
			tmr_q         <= '0;
			per_q         <= '0;
			to_hic_q      <= 1'b0;
			ocp_cnt_out   <= '0;
			rev_block_out <= 1'b0;
			hs_on_out     <= 1'b0;
			ls_on_out     <= 1'b0;
			skip_out      <= 1'b0;
			soft_out      <= 1'b0;
			run_out       <= 1'b0;
			hiccup_out    <= 1'b0;
		end else begin
			st_q          <= st_d;
			tmr_q         <= tmr_d;
			per_q         <= per_d;
			to_hic_q      <= to_hic_d;
			ocp_cnt_out   <= ocp_d;
			rev_block_out <= prebias_d;
			hs_on_out     <= hs_d;
			ls_on_out     <= ls_d;
			skip_out      <= act_d && skip_d;
			soft_out      <= st_d == CH_SOFT;
			run_out       <= st_d == CH_RUN;
			hiccup_out    <= st_d == CH_HICCUP;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_trip;
		ocp_trip && run_ok_in;
	endsequence
	sequence s_drain_done;
		st_q == CH_DRAIN && to_hic_q && zero_cur_in;
	endsequence

	AST_REV_BLOCK: assert property (rev_block_out |-> !ls_on_out)
		else $error("low side on while precharge guard active");
	AST_ILIM_CYCLE: assert property (
		(ilim_hit_in && act && run_ok_in && !ocp_trip) |=>
		!hs_on_out && (ls_on_out || rev_block_out))
		else $error("limit hit did not swap switches");
	AST_OCP_HICCUP: assert property (
		s_trip |=> st_q == CH_DRAIN && ls_on_out == !rev_block_out
		&& !hs_on_out)
		else $error("twentieth overcurrent did not start drain");
	AST_HIC_ENTRY: assert property (s_drain_done |=> st_q == CH_HICCUP)
		else $error("drain did not end in hiccup");
	AST_HIC_OFF: assert property (hiccup_out |-> !hs_on_out && !ls_on_out)
		else $error("switch on during hiccup");
	AST_HIC_RETRY: assert property (
		(st_q == CH_HICCUP && run_ok_in && tmr_end &&
		per_q == HICCUP_PERIODS - HIC_W'(1)) |=> soft_out && rev_block_out)
		else $error("hiccup did not retry after seven periods");
	AST_SKIP: assert property (skip_out |-> !hs_on_out)
		else $error("high side on during skipped pulse");

endmodule
`default_nettype wire

// ### design/bfs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bfs_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         arst_n_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta_q <= '0;
			q_out  <= '0;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end

endmodule
`default_nettype wire

// ### design/bfs_top.sv
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module bfs_top import bfs_pkg::*; #(
	parameter int SS_SHORT  = SS_SHORT_CYC,
	parameter int SS_LONG   = SS_LONG_CYC,
	parameter int SET_SHORT = SET_SHORT_CYC,
	parameter int SET_LONG  = SET_LONG_CYC
) (
	input  wire logic               ref_clk_in,
	input  wire logic               arst_n_in,
	input  wire logic [NCH-1:0]     channel_enable_pin_in,
	input  wire logic [NCH-1:0]     pvin_below_fall_in,
	input  wire logic [NCH-1:0]     pvin_above_rise_in,
	input  wire logic               bias_below_fall_in,
	input  wire logic               bias_above_rise_in,
	input  wire logic [NCH-1:0]     fb_in_window_in,
	input  wire logic [NCH-1:0]     fb_out_fault_in,
	input  wire logic [NCH-1:0]     ilim_hit_in,
	input  wire logic [NCH-1:0]     zero_current_in,
	input  wire logic [NCH-1:0]     ref_above_feedback_pin_in,
	input  wire logic [1:0]         min_on_short_in,
	input  wire logic               temp_above_powerup_in,
	input  wire logic               temp_above_shutdown_in,
	input  wire logic               temp_below_release_in,
	input  wire logic [STRAP_W-1:0] timing_config_strap_in,
	input  wire logic [NCH-1:0]     ilim_strap_in,
	input  wire logic               power_good_in,
	input  wire logic [ADDR_W-1:0]  avs_address_in,
	input  wire logic               avs_read_in,
	input  wire logic               avs_write_in,
	input  wire logic [DATA_W-1:0]  avs_writedata_in,
	input  wire logic [3:0]         avs_byteenable_in,
	output logic      [DATA_W-1:0]  avs_readdata_out,
	output logic                    avs_waitrequest_out,
	output logic      [NCH-1:0]     hs_on_out,
	output logic      [NCH-1:0]     ls_on_out,
	output logic      [NCH-1:0]     reverse_block_out,
	output logic      [1:0]         pulse_skip_out,
	output logic      [NCH-1:0]     ilim_high_sel_out,
	output logic                    soft_start_long_out,
	output logic                    fast_transient_out,
	output logic                    power_good_out,
	output logic                    power_good_oe_n_out
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [SYNC_W-1:0]  sync_q;
	logic [NCH-1:0]     en_s, pv_low_s, pv_high_s, win_s, flt_s;
	logic [NCH-1:0]     ilim_s, zero_s, refab_s, ilstrap_s;
	logic [1:0]         minon_s;
	logic               bias_low_s, bias_high_s, hot_s, tsd_hi_s, tsd_lo_s;
	logic               pg_pin_s;
	logic [STRAP_W-1:0] tstrap_s;

	bfs_sync #(.W(SYNC_W)) u_sync (
		.clk_in    (ref_clk_in),
		.arst_n_in (arst_n_in),
		.d_in      ({channel_enable_pin_in, pvin_below_fall_in,
			pvin_above_rise_in, fb_in_window_in, fb_out_fault_in,
			ilim_hit_in, zero_current_in, ref_above_feedback_pin_in,
			ilim_strap_in, min_on_short_in, bias_below_fall_in,
			bias_above_rise_in, temp_above_powerup_in,
			temp_above_shutdown_in, temp_below_release_in,
			power_good_in, timing_config_strap_in}),
		.q_out     (sync_q)
	);
	assign {en_s, pv_low_s, pv_high_s, win_s, flt_s, ilim_s, zero_s,
		refab_s, ilstrap_s, minon_s, bias_low_s, bias_high_s, hot_s,
		tsd_hi_s, tsd_lo_s, pg_pin_s, tstrap_s} = sync_q;

	////////////////////////////////////////////////////////////////////////
	// strap capture after reset release
	logic [1:0]         strap_wait_q;
	logic               strap_ok_q;
	logic [STRAP_W-1:0] tstrap_q;
	logic [NCH-1:0]     ilsel_q;

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			strap_wait_q <= '0;
			strap_ok_q   <= 1'b0;
			tstrap_q     <= '0;
			ilsel_q      <= '0;
		end else if (!strap_ok_q) begin
			strap_wait_q <= strap_wait_q + 2'(1);
			strap_ok_q   <= strap_wait_q == STRAP_LAT;
			tstrap_q     <= tstrap_s;
			ilsel_q      <= ilstrap_s;
		end
	end

	// row fifteen is unused and decodes like row zero
	wire       strap_long = tstrap_q >= STRAP_LONG_MIN && !(&tstrap_q);
	wire       fast_tr    = STRAP_FT_MAP[tstrap_q];
	wire [1:0] seq_bits   = STRAP_SEQ_MAP[{tstrap_q, 1'b0} +: 2];
	bfs_seq_e  seq_mode;
	assign seq_mode = bfs_seq_e'(seq_bits);
	wire bfs_tmr_t ss_cyc  = bfs_tmr_t'(strap_long ? SS_LONG : SS_SHORT);
	wire bfs_tmr_t set_lim = bfs_tmr_t'(strap_long ? SET_LONG : SET_SHORT);

	////////////////////////////////////////////////////////////////////////
	// lockouts with hysteresis
	logic [NCH-1:0] pv_lock_q;
	logic           bias_lock_q, tsd_q, hot_arm_q;

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pv_lock_q   <= '1;
			bias_lock_q <= 1'b1;
			tsd_q       <= 1'b0;
			hot_arm_q   <= 1'b1;
		end else begin
			pv_lock_q <= (pv_lock_q & ~pv_high_s) | pv_low_s;
			if (bias_low_s)
				bias_lock_q <= 1'b1;
			else if (bias_high_s)
				bias_lock_q <= 1'b0;
			if (tsd_hi_s)
				tsd_q <= 1'b1;
			else if (tsd_lo_s)
				tsd_q <= 1'b0;
			// armed only across first bias power-up
			if (!bias_lock_q && !hot_s)
				hot_arm_q <= 1'b0;
		end
	end

	wire hot_block = hot_arm_q && hot_s;

	////////////////////////////////////////////////////////////////////////
	// registers: control enables and forced-PWM
	logic [CTRL_FORCED_PULSE_WIDTH_MODE:0] ctrl_q;
	logic [NCH-1:0]     run_ok, go, soft_v, run_v, hic_v;
	logic [OCP_W-1:0]   ocp_v [NCH];
	logic [NCH-1:0]     skip_v;

	// dropping run_ok sends the channel off, through drain if it was switching; recovery re-runs soft start
	assign run_ok = en_s & ctrl_q[NCH-1:0] & ~pv_lock_q
		& {NCH{!bias_lock_q && !tsd_q && !hot_block && strap_ok_q}};

	// start order: a channel waits for its predecessor to regulate
	assign go[0] = seq_mode == SEQ_213 ? run_v[1]
		: seq_mode == SEQ_312 ? run_v[2] : 1'b1;
	assign go[1] = seq_mode == SEQ_123 ? run_v[0]
		: seq_mode == SEQ_312 ? run_v[0] : 1'b1;
	assign go[2] = seq_mode == SEQ_123 ? run_v[1]
		: seq_mode == SEQ_213 ? run_v[0] : 1'b1;

	////////////////////////////////////////////////////////////////////////
	// channel controllers
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			bfs_chan #(.SKIP_OK(gi < 2)) u_chan (
				.clk_in          (ref_clk_in),
				.arst_n_in       (arst_n_in),
				.ss_cyc_in       (ss_cyc),
				.run_ok_in       (run_ok[gi]),
				.go_in           (go[gi]),
				.forced_pulse_width_mode_in         (ctrl_q[CTRL_FORCED_PULSE_WIDTH_MODE]),
				.ilim_hit_in     (ilim_s[gi]),
				.zero_cur_in     (zero_s[gi]),
				.ref_above_fb_in (refab_s[gi]),
				.min_on_short_in (gi < 2 ? minon_s[gi % 2] : 1'b0),
				.hs_on_out       (hs_on_out[gi]),
				.ls_on_out       (ls_on_out[gi]),
				.rev_block_out   (reverse_block_out[gi]),
				.skip_out        (skip_v[gi]),
				.soft_out        (soft_v[gi]),
				.run_out         (run_v[gi]),
				.hiccup_out      (hic_v[gi]),
				.ocp_cnt_out     (ocp_v[gi])
			);
		end
	endgenerate
	// channel three never skips, so its bit is left unread
	assign pulse_skip_out = skip_v[1:0];

	////////////////////////////////////////////////////////////////////////
	// per-channel power good with deglitch
	logic [NCH-1:0] pg_int_q;
	logic [DG_W-1:0] dg_q [NCH];

	generate
		for (gi = 0; gi < NCH; gi++) begin : g_pg
			wire dg_full = dg_q[gi] == PG_DEGLITCH;
			always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					dg_q[gi]     <= '0;
					pg_int_q[gi] <= 1'b0;
				end else begin
					if (!flt_s[gi])
						dg_q[gi] <= '0;
					else if (!dg_full)
						dg_q[gi] <= dg_q[gi] + DG_W'(1);
					if (flt_s[gi] && dg_full)
						pg_int_q[gi] <= 1'b0;
					else if (win_s[gi])
						pg_int_q[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// combined power good with settle delay
	wire      all_good = &pg_int_q;
	bfs_tmr_t set_cnt_q;

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			set_cnt_q           <= '0;
			power_good_out      <= 1'b0;
			power_good_oe_n_out <= 1'b0;
		end else if (!all_good) begin
			set_cnt_q           <= '0;
			power_good_out      <= 1'b0;
			power_good_oe_n_out <= 1'b0;
		end else if (!power_good_out) begin
			set_cnt_q <= set_cnt_q + bfs_tmr_t'(1);
			if (set_cnt_q == set_lim - bfs_tmr_t'(1)) begin
				power_good_out      <= 1'b1;
				power_good_oe_n_out <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// strap-driven outputs
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ilim_high_sel_out   <= '0;
			soft_start_long_out <= 1'b0;
			fast_transient_out  <= 1'b0;
		end else begin
			ilim_high_sel_out   <= ilsel_q;
			soft_start_long_out <= strap_long;
			fast_transient_out  <= fast_tr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// avalon slave, one wait cycle on every access
	wire            req      = avs_read_in || avs_write_in;
	wire            sel_ctrl = avs_address_in == REG_CTRL;
	wire            sel_stat = avs_address_in == REG_STAT;
	wire            sel_chan = avs_address_in == REG_CHAN;
	wire            sel_strp = avs_address_in == REG_STRAP;
	wire            sel_ocp  = avs_address_in == REG_OCP;
	wire            wr_ctrl  = avs_write_in && !avs_waitrequest_out
		&& sel_ctrl && avs_byteenable_in[0];
	wire [DATA_W-1:0] rd_mux =
		sel_ctrl ? DATA_W'(ctrl_q) :
		sel_stat ? DATA_W'({pv_lock_q, hot_block, tsd_q, bias_lock_q,
			power_good_out, pg_pin_s, pg_int_q}) :
		sel_chan ? DATA_W'({hic_v, run_v, soft_v}) :
		sel_strp ? DATA_W'({fast_tr, strap_long, ilsel_q, tstrap_q}) :
		sel_ocp  ? DATA_W'({ocp_v[2], ocp_v[1], ocp_v[0]}) : '0;

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= '0;
			ctrl_q              <= CTRL_RST;
		end else begin
			avs_waitrequest_out <= !(req && avs_waitrequest_out);
			if (avs_read_in && avs_waitrequest_out)
				avs_readdata_out <= rd_mux;
			if (wr_ctrl)
				ctrl_q <= avs_writedata_in[CTRL_FORCED_PULSE_WIDTH_MODE:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);

	AST_GATE: assert property (1'b1 |=> (hs_on_out & ~$past(run_ok)) == '0)
		else $error("high side on for a blocked channel");
	AST_PVIN_OFF: assert property (
		(pv_lock_q != '0) |=> (hs_on_out & $past(pv_lock_q)) == '0)
		else $error("channel switching under input lockout");
	AST_BIAS_OFF: assert property (bias_lock_q |=> hs_on_out == '0)
		else $error("switching under bias lockout");
	AST_HOT_HOLD: assert property (hot_block |-> run_ok == '0)
		else $error("operation allowed during hot power-up");
	AST_TSD_OFF: assert property (tsd_q |=> hs_on_out == '0)
		else $error("switching during thermal shutdown");
	AST_TSD_HOLD: assert property (
		(tsd_q && !tsd_lo_s) |=> tsd_q)
		else $error("thermal shutdown left above release level");
	AST_PG_DROP: assert property (!all_good |=> !power_good_out
		&& !power_good_oe_n_out)
		else $error("power good not dropped on channel failure");
	AST_PG_SETTLE: assert property (
		$rose(power_good_out) |-> $past(set_cnt_q) == set_lim - bfs_tmr_t'(1))
		else $error("power good rose before settle delay");
	AST_PG_DEGLITCH: assert property (
		$fell(pg_int_q[0]) |-> $past(flt_s[0]) && $past(dg_q[0]) == PG_DEGLITCH)
		else $error("channel good cleared without deglitch");
	AST_PG_SET: assert property (
		(win_s[1] && !flt_s[1]) |=> pg_int_q[1])
		else $error("channel good not set inside window");

endmodule
`default_nettype wire

// ### dv/bfs_pg_host.sv
`timescale 1ns/1ps
`default_nettype none
// system side of the open-drain good wire
module bfs_pg_host (
	input  wire logic oe_n_in,
	output logic      pin_out
);
	// released pin rests at the pull-up, never at a stale value
	assign pin_out = oe_n_in ? 1'b1 : 1'b0;
endmodule
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import bfs_pkg::*;;
	logic       clk = 0;
	logic       rst_n = 0;
	logic [2:0] en, pv_lo, pv_hi, win, flt, ilim, zc, ref_ok, ils;
	logic [2:0] hs, ls, rvb, ihs;
	logic       bl, bh, thot, thermal_shutdown, trel, rd, wr, pgin, wrq, pg, pg_oen;
	logic       sslong, ft;
	logic [1:0] mos, skp;
	logic [3:0] row, be;
	logic [4:0] adr;
	logic [31:0] wd, rdat, q;
	int         err_total = 0;
	int         checks = 0;
	int         ss, st, c;

	bfs_top #(.SS_SHORT(8), .SS_LONG(16), .SET_SHORT(10), .SET_LONG(40))
	u_bfs_top (
	.ref_clk_in(clk), .arst_n_in(rst_n), .channel_enable_pin_in(en),
	.pvin_below_fall_in(pv_lo), .pvin_above_rise_in(pv_hi),
	.bias_below_fall_in(bl), .bias_above_rise_in(bh),
	.fb_in_window_in(win), .fb_out_fault_in(flt), .ilim_hit_in(ilim),
	.zero_current_in(zc), .ref_above_feedback_pin_in(ref_ok),
	.min_on_short_in(mos), .temp_above_powerup_in(thot),
	.temp_above_shutdown_in(thermal_shutdown), .temp_below_release_in(trel),
	.timing_config_strap_in(row), .ilim_strap_in(ils), .power_good_in(pgin),
	.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
	.avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
	.avs_waitrequest_out(wrq), .hs_on_out(hs), .ls_on_out(ls),
	.reverse_block_out(rvb), .pulse_skip_out(skp), .ilim_high_sel_out(ihs),
	.soft_start_long_out(sslong), .fast_transient_out(ft),
	.power_good_out(pg), .power_good_oe_n_out(pg_oen));

	bfs_pg_host u_bfs_pg_host (.oe_n_in(pg_oen), .pin_out(pgin));

	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	function bit slow(input logic [3:0] r);
		return r >= 4'h7 && r != 4'hf;
	endfunction
	function bit fast(input logic [3:0] r);
		return (r >= 4'h4 && r <= 4'h6) || (r >= 4'hb && r != 4'hf);
	endfunction
	task complete_run;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task lim(input int n);
		if (n >= 400) begin
			err_total++;
			$display("mismatch at %0t: wait ran out", $time);
			complete_run;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		for (n = 0; n < 400 && wrq !== 1'b0; n++) @(posedge clk);
		lim(n);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// p selects: power good level, else high-side permits of mask m
	task wt(input bit p, input logic [2:0] m);
		int n;
		for (n = 0; n < 400; n++) begin
			@(posedge clk);
			if (p ? pg === m[0] : (hs & m) === m)
				break;
		end
		lim(n);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		{pv_lo, win, flt, ilim, ref_ok, rd, wr, bl, thermal_shutdown, adr, wd, mos} = '0;
		{en, pv_hi, zc, bh, trel, thot, be} = '1;
		void'($urandom(32'hc663));
		row = 4'($urandom);
		ils = 3'($urandom);
		ss = slow(row) ? 16 : 8;
		st = slow(row) ? 40 : 10;
		cyc(6);
		rst_n <= 1'b1;
		cyc(20);
		chk(hs | ls, 0);
		thot <= 1'b0;
		wt(0, 3'h7);
		thot <= 1'b1;
		cyc(5);
		chk(hs, 3'h7);
		chk({ft, sslong, ihs}, {fast(row), slow(row), ils});
		bus(0, REG_CTRL, 0);
		chk(q, 32'hf);
		bus(0, 5'h14, 0);
		chk(q, 0);
		chk({rvb, ls}, 6'h38);
		ref_ok <= '1;
		cyc(5);
		chk({rvb, ls}, 6'h07);
		$display("done start");
		win <= '1;
		cyc(st + 3);
		chk(pg, 0);
		cyc(1);
		chk(pg, 1);
		chk(pgin, 1);
		bus(0, REG_STAT, 0);
		chk(q[10:0], 11'h01f);
		c = $urandom % 3;
		win[c] <= 1'b0;
		flt[c] <= 1'b1;
		cyc(8);
		chk(pg, 1);
		cyc(1);
		chk({pg, pgin}, 0);
		win <= '1;
		flt <= '0;
		wt(1, 3'h1);
		$display("done good");
		// hold the current limit long enough to pass the event count
		zc <= '0;
		ilim <= 3'h1;
		cyc(5);
		chk({hs[0], ls[0]}, 2'h1);
		cyc(25);
		bus(0, REG_OCP, 0);
		chk({hs[0], ls[0], q[4:0]}, 7'h34);
		zc <= '1;
		ilim <= '0;
		cyc(5);
		chk({hs[0], ls[0]}, 0);
		cyc(7 * ss - 2);
		chk(hs[0], 0);
		cyc(1);
		chk(hs[0], 1);
		$display("done overcurrent");
		for (int k = 0; k < 3; k++) begin
			thermal_shutdown <= (k == 0);
			trel <= (k != 0);
			bl <= (k == 1);
			bh <= (k != 1);
			pv_lo <= {3{k == 2}};
			pv_hi <= {3{k != 2}};
			cyc(10);
			chk(hs | ls, 0);
			// k = 0: over-temperature gone but release level not yet reached; k = 1, 2: own lockout still held
			thermal_shutdown <= 1'b0;
			cyc(10);
			chk(hs | ls, 0);
			{thermal_shutdown, trel, bl, bh, pv_lo, pv_hi} <= 10'h147;
			wt(0, 3'h7);
		end
		$display("done lockouts");
		bus(1, REG_CTRL, 0);
		cyc(10);
		chk(hs, 0);
		bus(1, REG_CTRL, 32'hf);
		wt(0, 3'h7);
		be <= 4'he;
		bus(1, REG_CTRL, 0);
		be <= 4'hf;
		cyc(5);
		chk(hs, 3'h7);
		en <= 3'h6;
		cyc(10);
		chk(hs, 3'h6);
		en <= 3'h7;
		wt(0, 3'h7);
		mos <= 2'h3;
		cyc(5);
		chk({skp, hs}, 5'h1c);
		bus(1, REG_CTRL, 32'h7);
		cyc(5);
		chk({skp, hs}, 5'h07);
		mos <= 2'h0;
		bus(1, REG_CTRL, 32'hf);
		$display("done enables");
		complete_run;
	end
endmodule
`default_nettype wire

// ### include/bfs_pkg.sv
package bfs_pkg;

	////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int CLK_KHZ        = 10000;
	localparam int SS_SHORT_US    = 2200;
	localparam int SS_LONG_US     = 17300;
	localparam int SET_SHORT_US   = 2600;
	localparam int SET_LONG_MULT  = 8;
	localparam int SS_SHORT_CYC   = SS_SHORT_US * CLK_KHZ / 1000;
	localparam int SS_LONG_CYC    = SS_LONG_US * CLK_KHZ / 1000;
	localparam int SET_SHORT_CYC  = SET_SHORT_US * CLK_KHZ / 1000;
	localparam int SET_LONG_CYC   = SET_SHORT_CYC * SET_LONG_MULT;

	localparam int TW = 18;
	typedef logic [TW-1:0] bfs_tmr_t;

	////////////////////////////////////////////////////////////////////////
	// fault counting
	localparam int              NCH            = 3;
	localparam int              OCP_W          = 5;
	localparam logic [OCP_W-1:0] OCP_LIMIT     = 5'h14;
	localparam int              HIC_W          = 3;
	localparam logic [HIC_W-1:0] HICCUP_PERIODS = 3'h7;
	localparam int              DG_W           = 3;
	localparam logic [DG_W-1:0]  PG_DEGLITCH   = 3'h4;
	localparam logic [1:0]       STRAP_LAT     = 2'h2;
	localparam int              SYNC_W         = 39;

	////////////////////////////////////////////////////////////////////////
	// timing strap decode, one entry per strap row
	localparam int          STRAP_W        = 4;
	localparam logic [15:0] STRAP_FT_MAP   = 16'h7870;
	localparam logic [31:0] STRAP_SEQ_MAP  = 32'h3939_34e4;
	localparam logic [3:0]  STRAP_LONG_MIN = 4'h7;

	typedef enum logic [1:0] {SEQ_NONE, SEQ_123, SEQ_213, SEQ_312} bfs_seq_e;
	typedef enum logic [2:0] {CH_OFF, CH_SOFT, CH_RUN, CH_DRAIN, CH_HICCUP}
		bfs_chst_e;

	////////////////////////////////////////////////////////////////////////
	// register map, byte addresses
	localparam int         ADDR_W    = 5;
	localparam int         DATA_W    = 32;
	localparam logic [4:0] REG_CTRL  = 5'h00;
	localparam logic [4:0] REG_STAT  = 5'h04;
	localparam logic [4:0] REG_CHAN  = 5'h08;
	localparam logic [4:0] REG_STRAP = 5'h0c;
	localparam logic [4:0] REG_OCP   = 5'h10;
	localparam int         CTRL_FORCED_PULSE_WIDTH_MODE = 3;
	localparam logic [3:0] CTRL_RST  = 4'hf;

endpackage
